// ---- inc/npi_regs.svh ----
`ifndef NPI_REGS_SVH
`define NPI_REGS_SVH
// How it works
// - service starts at an instruction boundary reported by the core, or at once while the core is halted or waiting
// - entry asks the core to push program counter, index, accumulator and cc
// - maskable entry loads cc priority bits from the vector's stored priority
// - after the push the program counter loads the fixed vector address
// - return_from_interrupt restores the popped priority bits
// - priority codes 10,01,00,11 are levels 0,1,2,3; level 3 masks
// - highest software priority wins, ties go to fixed hardware priority
// - unserved edge and peripheral requests stay latched until they become the highest; low-level line requests are not latched
// - reset and trap rank above every maskable request
// - trap is taken whatever the cc priority bits hold
// - trap stacks, loads its vector and sets level 3; reset does not stack
// - of the non-maskable sources only reset leaves halt; trap is not taken while halted
// - executing the trap instruction raises trap with the normal sequence
// - reset is served first and its routine runs at level 3
// - maskable request served only if enabled and above current level
// - external lines wake from halt; sense chosen by ext_irq_sense_ctrl
// - edge requests are latched and cleared on service entry
// - selected pins sharing one line are ORed together
// - peripheral request only while its flag and its enable are both set
// - the peripheral clear sequence drops the latched request
// - any request wakes from wait; only capable ones wake from halt
// - first service after halt is a halt-capable one by normal selection
// - writing level 0 into a vector priority keeps the old value
// - all vector priorities reset to level 3
`define NPI_NVEC      14
`define NPI_NEXT      4
`define NPI_NPIN      8
`define NPI_EXT_VEC0  2
`define NPI_HALT_WAKE 14'h00be
`define NPI_LVL0      2'b10
`define NPI_LVL1      2'b01
`define NPI_LVL2      2'b00
`define NPI_LVL3      2'b11
`define NPI_SNS_LOW   2'b00
`define NPI_SNS_RISE  2'b01
`define NPI_SNS_FALL  2'b10
`define NPI_SNS_BOTH  2'b11
`define NPI_SNS_RST   8'h00
`define NPI_PSEL_RST  8'hff
`define NPI_VEC_RST   16'hfffe
`define NPI_VEC_TRAP  16'hfffc
`define NPI_VEC0      16'hfffa
`define NPI_OFF_CC    5'h00
`define NPI_OFF_ISPR0 5'h04
`define NPI_OFF_ISPR3 5'h10
`define NPI_OFF_EXT_IRQ_SENSE_CTRL  5'h14
`define NPI_OFF_PSEL  5'h18
`define NPI_OFF_PEND  5'h1c
`endif

// ---- inc/npi_pkg.sv ----
`include "npi_regs.svh"
package npi_pkg;
    typedef enum logic [1:0] {NPI_RST, NPI_IDLE, NPI_PUSH} npi_st_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } npi_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } npi_avs_rsp_s;

    typedef struct packed {
        logic       instr_done;
        logic       trap_exec;
        logic       return_from_interrupt;
        logic [1:0] return_from_interrupt_prio;
        logic       cc_wr;
        logic [1:0] cc_val;
        logic       halt_enter;
        logic       wait_enter;
        logic       push_ack;
    } npi_cpu_in_s;

    typedef struct packed {
        logic        push_req;
        logic        vec_load;
        logic [15:0] vec_addr;
        logic [1:0]  cc_prio;
        logic        wake;
        logic        halted;
        logic        waiting;
    } npi_cpu_out_s;

    typedef struct packed {
        npi_st_e                   st;
        npi_avs_rsp_s              avs;
        npi_cpu_out_s              cpu;
        logic [1:0]                nprio;
        logic [15:0]               nvec;
        logic                      trap_pend;
        logic [2*`NPI_NVEC-1:0]    isp;
        logic [7:0]                sense;
        logic [7:0]                psel;
        logic [`NPI_NPIN-1:0]      s1;
        logic [`NPI_NPIN-1:0]      s2;
        logic [`NPI_NPIN-1:0]      s3;
        logic [`NPI_NPIN-1:0]      flt;
        logic [`NPI_NEXT-1:0]      lvl;
        logic [`NPI_NEXT-1:0]      elat;
        logic [`NPI_NVEC-1:0]      plat;
    } npi_state_s;
endpackage

// ---- verilog/npi_ctrl.sv ----
`timescale 1ns/1ps
`include "npi_regs.svh"
module npi_ctrl #(
    parameter logic [`NPI_NVEC-1:0] HALT_WAKE = `NPI_HALT_WAKE
) (
    input  wire logic                  clk_sys,  // cpu clock, 200 MHz
    input  wire logic                  rst_b,    // sync reset, active low
    input  wire npi_pkg::npi_avs_req_s avs_req,  // avalon slave request
    output npi_pkg::npi_avs_rsp_s      avs_rsp,  // avalon slave answer
    input  wire npi_pkg::npi_cpu_in_s  cpu_in,   // core events
    output npi_pkg::npi_cpu_out_s      cpu_out,  // service requests to core
    input  wire logic [`NPI_NPIN-1:0]  ext_pin,  // external interrupt pins
    input  wire logic [`NPI_NVEC-1:0]  per_flag, // peripheral status flags
    input  wire logic [`NPI_NVEC-1:0]  per_en,   // peripheral enables
    input  wire logic [`NPI_NVEC-1:0]  per_clr   // peripheral clear sequence done
);

    npi_pkg::npi_state_s s_ff;
    npi_pkg::npi_state_s nxt_s;

    logic [`NPI_NEXT-1:0] line_lvl;
    logic [`NPI_NEXT-1:0] line_edge;
    logic [`NPI_NVEC-1:0] pend;
    logic [`NPI_NVEC-1:0] wake_msk;
    logic                 found;
    logic [3:0]           bidx;
    logic [1:0]           brank;
    logic [1:0]           sns;
    logic                 rise;
    logic                 fall;
    logic                 trap_now;
    logic                 take;
    logic [31:0]          rdata;
    int                   v;
    int                   kb;

    // rank of a priority code, level 0 lowest
    function automatic logic [1:0] npi_rank(input logic [1:0] p);
        case (p)
            `NPI_LVL0: npi_rank = 2'h0;
            `NPI_LVL1: npi_rank = 2'h1;
            `NPI_LVL2: npi_rank = 2'h2;
            default:   npi_rank = 2'h3;
        endcase
    endfunction

    // true when vector v belongs to an external line
    function automatic logic npi_is_ext(input int vv);
        npi_is_ext = (vv >= `NPI_EXT_VEC0) && (vv < `NPI_EXT_VEC0 + `NPI_NEXT);
    endfunction

    assign avs_rsp = s_ff.avs;
    assign cpu_out = s_ff.cpu;

    // next state of the whole controller
    always_comb begin
        nxt_s     = s_ff;
        line_lvl  = '0;
        line_edge = '0;
        pend      = '0;
        found     = 1'b0;
        bidx      = 4'h0;
        brank     = 2'h0;
        sns       = 2'h0;
        rise      = 1'b0;
        fall      = 1'b0;
        take      = 1'b0;
        rdata     = 32'h0;
        v         = 0;
        kb        = 0;
        nxt_s.cpu.vec_load = 1'b0;
        nxt_s.cpu.wake     = 1'b0;

        // pin synchroniser, a change counts once stages two and three agree
        nxt_s.s1 = ext_pin;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        for (int i = 0; i < `NPI_NPIN; i++) begin
            if (s_ff.s2[i] == s_ff.s3[i]) begin
                nxt_s.flt[i] = s_ff.s2[i];
            end
        end

        // line level and edge per sense setting
        for (int j = 0; j < `NPI_NEXT; j++) begin
            line_lvl[j] = |(s_ff.flt[2*j +: 2] & s_ff.psel[2*j +: 2]);
            sns  = s_ff.sense[2*j +: 2];
            rise = line_lvl[j] & ~s_ff.lvl[j];
            fall = ~line_lvl[j] & s_ff.lvl[j];
            if (sns == `NPI_SNS_RISE) begin
                line_edge[j] = rise;
            end else if (sns == `NPI_SNS_FALL) begin
                line_edge[j] = fall;
            end else if (sns == `NPI_SNS_BOTH) begin
                line_edge[j] = rise | fall;
            end else begin
                line_edge[j] = 1'b0;
            end
        end
        nxt_s.lvl = line_lvl;

        // peripheral latch, a new flag wins over the clear
        nxt_s.plat = (s_ff.plat & ~per_clr) | (per_flag & per_en);

        // pending view of every vector
        for (int i = 0; i < `NPI_NVEC; i++) begin
            if (npi_is_ext(i)) begin
                if (s_ff.sense[2*(i-`NPI_EXT_VEC0) +: 2] == `NPI_SNS_LOW) begin
                    pend[i] = ~line_lvl[i-`NPI_EXT_VEC0];
                end else begin
                    pend[i] = s_ff.elat[i-`NPI_EXT_VEC0];
                end
            end else begin
                pend[i] = s_ff.plat[i] & per_flag[i] & per_en[i];
            end
        end

        // while halted only halt-capable vectors compete
        wake_msk = s_ff.cpu.halted ? HALT_WAKE : '1;

        // pick highest software priority, lowest index on a tie
        for (int i = 0; i < `NPI_NVEC; i++) begin
            if (pend[i] && wake_msk[i]
                && npi_rank(s_ff.isp[2*i +: 2]) > npi_rank(s_ff.cpu.cc_prio)
                && (!found || npi_rank(s_ff.isp[2*i +: 2]) > brank)) begin
                found = 1'b1;
                bidx  = 4'(i);
                brank = npi_rank(s_ff.isp[2*i +: 2]);
            end
        end

        // trap ignores the cc level and ranks above all maskable ones
        trap_now = s_ff.trap_pend | cpu_in.trap_exec;

        // service sequencer
        case (s_ff.st)
            npi_pkg::NPI_RST: begin
                nxt_s.cpu.vec_addr = `NPI_VEC_RST;
                nxt_s.cpu.vec_load = 1'b1;
                nxt_s.cpu.cc_prio  = `NPI_LVL3;
                nxt_s.st           = npi_pkg::NPI_IDLE;
            end
            npi_pkg::NPI_IDLE: begin
                if (cpu_in.return_from_interrupt) begin
                    nxt_s.cpu.cc_prio = cpu_in.return_from_interrupt_prio;
                end else if (cpu_in.cc_wr) begin
                    nxt_s.cpu.cc_prio = cpu_in.cc_val;
                end
                if (cpu_in.halt_enter) begin
                    nxt_s.cpu.halted = 1'b1;
                end
                if (cpu_in.wait_enter) begin
                    nxt_s.cpu.waiting = 1'b1;
                end
                // boundary, or core asleep with nothing executing
                if ((cpu_in.instr_done || s_ff.cpu.halted || s_ff.cpu.waiting)
                    && ((trap_now && !s_ff.cpu.halted) || found)) begin
                    take               = 1'b1;
                    nxt_s.cpu.wake     = s_ff.cpu.halted | s_ff.cpu.waiting;
                    nxt_s.cpu.halted   = 1'b0;
                    nxt_s.cpu.waiting  = 1'b0;
                    nxt_s.cpu.push_req = 1'b1;
                    nxt_s.st           = npi_pkg::NPI_PUSH;
                    if (trap_now && !s_ff.cpu.halted) begin
                        nxt_s.nvec  = `NPI_VEC_TRAP;
                        nxt_s.nprio = `NPI_LVL3;
                    end else begin
                        nxt_s.nvec  = `NPI_VEC0 - {11'h0, bidx, 1'b0};
                        nxt_s.nprio = s_ff.isp[2*bidx +: 2];
                        if (npi_is_ext(int'(bidx))) begin
                            nxt_s.elat[int'(bidx) - `NPI_EXT_VEC0] = 1'b0;
                        end
                    end
                end
            end
            npi_pkg::NPI_PUSH: begin
                // context is on the stack, now raise level and jump
                if (cpu_in.push_ack) begin
                    nxt_s.cpu.push_req = 1'b0;
                    nxt_s.cpu.cc_prio  = s_ff.nprio;
                    nxt_s.cpu.vec_addr = s_ff.nvec;
                    nxt_s.cpu.vec_load = 1'b1;
                    nxt_s.st           = npi_pkg::NPI_IDLE;
                end
            end
            default: begin
                nxt_s.st = npi_pkg::NPI_IDLE;
            end
        endcase

        // trap stays pending until taken, a trap raised in the taking cycle is not kept pending
        nxt_s.trap_pend = (s_ff.trap_pend & ~(take & trap_now & !s_ff.cpu.halted))
                          | (cpu_in.trap_exec & ~take);
        // edges set after the entry clear so a fresh edge is kept
        nxt_s.elat = nxt_s.elat | line_edge;

        // register read decode
        if (avs_req.address == `NPI_OFF_CC) begin
            rdata[1:0] = s_ff.cpu.cc_prio;
            rdata[2]   = s_ff.cpu.halted;
            rdata[3]   = s_ff.cpu.waiting;
            rdata[4]   = s_ff.trap_pend;
        end else if (avs_req.address >= `NPI_OFF_ISPR0
                     && avs_req.address <= `NPI_OFF_ISPR3
                     && avs_req.address[1:0] == 2'h0) begin
            kb = int'(avs_req.address[4:2]) - int'(`NPI_OFF_ISPR0 >> 2);
            for (int f = 0; f < 4; f++) begin
                v = 4 * kb + f;
                rdata[2*f +: 2] = (v < `NPI_NVEC) ? s_ff.isp[2*v +: 2] : `NPI_LVL3;
            end
        end else if (avs_req.address == `NPI_OFF_EXT_IRQ_SENSE_CTRL) begin
            rdata[7:0] = s_ff.sense;
        end else if (avs_req.address == `NPI_OFF_PSEL) begin
            rdata[7:0] = s_ff.psel;
        end else if (avs_req.address == `NPI_OFF_PEND) begin
            rdata[`NPI_NVEC-1:0] = pend;
        end else begin
            rdata = 32'h0;
        end

        // one wait cycle, then a single-cycle answer
        nxt_s.avs.waitrequest = 1'b1;
        if ((avs_req.read || avs_req.write) && s_ff.avs.waitrequest) begin
            nxt_s.avs.waitrequest = 1'b0;
            nxt_s.avs.readdata    = rdata;
        end

        // writes complete on the edge that sees waitrequest low
        if (avs_req.write && !s_ff.avs.waitrequest && avs_req.byteenable[0]) begin
            if (avs_req.address >= `NPI_OFF_ISPR0
                && avs_req.address <= `NPI_OFF_ISPR3
                && avs_req.address[1:0] == 2'h0) begin
                kb = int'(avs_req.address[4:2]) - int'(`NPI_OFF_ISPR0 >> 2);
                for (int f = 0; f < 4; f++) begin
                    v = 4 * kb + f;
                    if (v < `NPI_NVEC
                        && avs_req.writedata[2*f +: 2] != `NPI_LVL0) begin
                        nxt_s.isp[2*v +: 2] = avs_req.writedata[2*f +: 2];
                    end
                end
            end else if (avs_req.address == `NPI_OFF_EXT_IRQ_SENSE_CTRL) begin
                nxt_s.sense = avs_req.writedata[7:0];
            end else if (avs_req.address == `NPI_OFF_PSEL) begin
                nxt_s.psel = avs_req.writedata[7:0];
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_ff                 <= '0;
            s_ff.st              <= npi_pkg::NPI_RST;
            s_ff.avs.waitrequest <= 1'b1;
            s_ff.cpu.cc_prio     <= `NPI_LVL3;
            s_ff.isp             <= '1;
            s_ff.sense           <= `NPI_SNS_RST;
            s_ff.psel            <= `NPI_PSEL_RST;
            // pins idle high, so the filter and edge history start there
            s_ff.s1              <= '1;
            s_ff.s2              <= '1;
            s_ff.s3              <= '1;
            s_ff.flt             <= '1;
            s_ff.lvl             <= '1;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule

// ---- verification/npi_core_mdl.sv ----
`timescale 1ns/1ps
module npi_core_mdl (
    input  wire logic clk_sys,    // cpu clock
    input  wire logic rst_b,      // sync reset, active low
    input  wire logic push_req,   // context push request
    input  wire logic halted,     // core stopped in halt
    input  wire logic waiting,    // core stopped in wait
    input  wire logic slow,       // stretch the push
    output logic      push_ack,   // push finished pulse
    output logic      instr_done  // instruction boundary pulse
);
    logic [3:0] cnt_ff; // push cycles spent

    // core pushes the context in one or six cycles, runs only when awake
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_ff <= 4'h0;
            push_ack <= 1'b0;
            instr_done <= 1'b0;
        end else begin
            push_ack <= 1'b0;
            instr_done <= !halted && !waiting && !instr_done;
            if (push_req && !push_ack) begin
                cnt_ff <= cnt_ff + 4'h1;
                if (cnt_ff == (slow ? 4'h5 : 4'h0)) begin
                    push_ack <= 1'b1;
                    cnt_ff <= 4'h0;
                end
            end
        end
    end
endmodule

// ---- verification/npi_ctrl_props.sv ----
`timescale 1ns/1ps
`include "npi_regs.svh"
module npi_ctrl_props (
    input wire logic                  clk_sys, // cpu clock
    input wire logic                  rst_b,   // sync reset, active low
    input wire npi_pkg::npi_cpu_in_s  cpu_in,  // core events
    input wire npi_pkg::npi_cpu_out_s cpu_out  // service requests
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // steps of an entry: push done, then vector load
    sequence s_ack;
        cpu_out.push_req && cpu_in.push_ack;
    endsequence
    sequence s_nmi_load;
        cpu_out.vec_load
            && (cpu_out.vec_addr == `NPI_VEC_TRAP || cpu_out.vec_addr == `NPI_VEC_RST);
    endsequence
    property p_push_hold;
        cpu_out.push_req && !cpu_in.push_ack |=> cpu_out.push_req;
    endproperty
    property p_push_vec;
        s_ack |=> cpu_out.vec_load && !cpu_out.push_req;
    endproperty
    property p_vec_pulse;
        cpu_out.vec_load |=> !cpu_out.vec_load;
    endproperty
    property p_nmi_lvl;
        s_nmi_load |-> cpu_out.cc_prio == `NPI_LVL3;
    endproperty
    property p_rst_vec;
        $rose(rst_b) |-> ##[1:2] (cpu_out.vec_load && cpu_out.vec_addr == `NPI_VEC_RST);
    endproperty
    property p_return_from_interrupt;
        cpu_in.return_from_interrupt && !cpu_out.push_req |=> cpu_out.cc_prio == $past(cpu_in.return_from_interrupt_prio);
    endproperty
    property p_no_lvl0;
        cpu_out.vec_load |-> cpu_out.cc_prio != `NPI_LVL0;
    endproperty
    property p_wake;
        $rose(cpu_out.push_req) && $past(cpu_out.halted || cpu_out.waiting) |-> cpu_out.wake;
    endproperty
    property p_wake_pulse;
        cpu_out.wake |=> !cpu_out.wake;
    endproperty
    property p_trap;
        cpu_in.trap_exec && !cpu_out.push_req && !cpu_out.vec_load && !cpu_out.halted
            |-> ##[1:4] cpu_out.push_req;
    endproperty
    a_push_hold: assert property (p_push_hold) else $error("push request dropped early");
    a_push_vec: assert property (p_push_vec) else $error("no vector load after push");
    a_vec_pulse: assert property (p_vec_pulse) else $error("vector load too long");
    a_nmi_lvl: assert property (p_nmi_lvl) else $error("nmi entry not at level 3");
    a_rst_vec: assert property (p_rst_vec) else $error("no reset vector load");
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not restore priority");
    a_no_lvl0: assert property (p_no_lvl0) else $error("entry at level 0");
    a_wake: assert property (p_wake) else $error("no wake on service from sleep");
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
    a_trap: assert property (p_trap) else $error("trap not taken");
endmodule

bind npi_ctrl npi_ctrl_props u_npi_ctrl_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .cpu_in(cpu_in), .cpu_out(cpu_out));

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "npi_regs.svh"
module tb_top;
    logic                  clk_sys;     // 200 MHz clock
    logic                  rst_b;       // sync reset
    logic                  slow;        // slow core pushes
    npi_pkg::npi_avs_req_s avs_req;     // bus request
    npi_pkg::npi_avs_rsp_s avs_rsp;     // bus answer
    npi_pkg::npi_cpu_in_s  ci;          // bench core events
    npi_pkg::npi_cpu_in_s  cpu_in;      // merged core events
    npi_pkg::npi_cpu_out_s cpu_out;     // controller outputs
    logic                  ack;         // model push ack
    logic                  done;        // model boundary
    logic [7:0]            ext_pin;     // external pins
    logic [`NPI_NVEC-1:0]  per_flag;    // peripheral flags
    logic [`NPI_NVEC-1:0]  per_en;      // peripheral enables
    logic [`NPI_NVEC-1:0]  per_clr;     // clear sequence pulses
    logic [31:0]           q;           // read data
    int                    miscompares; // mismatches
    int                    cmp_count;   // comparisons

    npi_ctrl u_npi_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .avs_req(avs_req),
        .avs_rsp(avs_rsp), .cpu_in(cpu_in), .cpu_out(cpu_out), .ext_pin(ext_pin),
        .per_flag(per_flag), .per_en(per_en), .per_clr(per_clr));
    npi_core_mdl u_npi_core_mdl (.clk_sys(clk_sys), .rst_b(rst_b), .push_req(cpu_out.push_req),
        .halted(cpu_out.halted), .waiting(cpu_out.waiting), .slow(slow), .push_ack(ack),
        .instr_done(done));

    // clock
    always #2.5 clk_sys = ~clk_sys;
    // model drives push ack and boundaries, bench the rest
    always_comb begin
        cpu_in = ci;
        cpu_in.instr_done = done;
        cpu_in.push_ack = ack;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_req.read <= !wr;
        avs_req.write <= wr;
        avs_req.address <= a;
        avs_req.writedata <= 32'(d);
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
        q = avs_rsp.readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk("readdata", 32'(e), q);
    endtask

    task automatic wait_vec(input logic [15:0] va, input logic [1:0] pr);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cpu_out.vec_load !== 1'b1 && n < 400);
        chk("vec_load", 32'h1, 32'(cpu_out.vec_load));
        chk("vec_addr", 32'(va), 32'(cpu_out.vec_addr));
        chk("cc_prio", 32'(pr), 32'(cpu_out.cc_prio));
    endtask

    task automatic results;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #100us;
        miscompares++;
        results;
    end

    // main sequence
    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        slow = 1'b0;
        avs_req = '0;
        avs_req.byteenable = 4'hf;
        ci = '0;
        ext_pin = 8'hff;
        per_flag = '0;
        per_en = '0;
        per_clr = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_vec(`NPI_VEC_RST, `NPI_LVL3);
        for (int i = 0; i < 4; i++) begin
            rd(5'(`NPI_OFF_ISPR0 + 4 * i), 8'hff);
        end
        rd(`NPI_OFF_EXT_IRQ_SENSE_CTRL, 8'h00);
        acc(1'b1, `NPI_OFF_CC, 8'h00);
        rd(`NPI_OFF_CC, 8'h03);
        acc(1'b1, `NPI_OFF_ISPR0, 8'hcf);
        acc(1'b1, `NPI_OFF_ISPR0, 8'h64);
        rd(`NPI_OFF_ISPR0, 8'h44);
        acc(1'b1, `NPI_OFF_ISPR0 + 5'h8, 8'h30);
        acc(1'b1, `NPI_OFF_EXT_IRQ_SENSE_CTRL, 8'h02);
        // open to level 0, then three peripherals with one not enabled
        @(posedge clk_sys);
        ci.cc_wr <= 1'b1;
        ci.cc_val <= `NPI_LVL0;
        @(posedge clk_sys);
        ci <= '0;
        per_en <= 14'h0300;
        per_flag <= 14'h0700;
        wait_vec(`NPI_VEC0 - 16'd16, `NPI_LVL2);
        per_flag[8] <= 1'b0;
        @(posedge clk_sys);
        per_clr <= 14'h0100;
        @(posedge clk_sys);
        per_clr <= '0;
        ci.return_from_interrupt <= 1'b1;
        ci.return_from_interrupt_prio <= `NPI_LVL0;
        @(posedge clk_sys);
        ci <= '0;
        wait_vec(`NPI_VEC0 - 16'd18, `NPI_LVL2);
        slow <= 1'b1;
        per_en[10] <= 1'b1;
        wait_vec(`NPI_VEC0 - 16'd20, `NPI_LVL3);
        per_flag <= '0;
        @(posedge clk_sys);
        per_clr <= '1;
        ci.trap_exec <= 1'b1;
        @(posedge clk_sys);
        per_clr <= '0;
        ci <= '0;
        wait_vec(`NPI_VEC_TRAP, `NPI_LVL3);
        // halt at level 0, a non-waking source first, then a falling pin
        @(posedge clk_sys);
        ci.cc_wr <= 1'b1;
        ci.cc_val <= `NPI_LVL0;
        ci.halt_enter <= 1'b1;
        @(posedge clk_sys);
        ci <= '0;
        rd(`NPI_OFF_CC, 8'h06);
        acc(1'b1, `NPI_OFF_ISPR0 + 5'h8, 8'h03);
        per_flag[8] <= 1'b1;
        per_en <= 14'h0100;
        repeat (4) @(posedge clk_sys);
        rd(`NPI_OFF_CC, 8'h06);
        ext_pin[1:0] <= 2'b00;
        wait_vec(`NPI_VEC0 - 16'd4, `NPI_LVL2);
        wait_vec(`NPI_VEC0 - 16'd16, `NPI_LVL3);
        per_flag <= '0;
        @(posedge clk_sys);
        per_clr <= 14'h0100;
        @(posedge clk_sys);
        per_clr <= '0;
        rd(`NPI_OFF_PEND, 8'h00);
        // wait at level 0, a source that cannot leave halt still ends wait
        @(posedge clk_sys);
        ci.cc_wr <= 1'b1;
        ci.cc_val <= `NPI_LVL0;
        ci.wait_enter <= 1'b1;
        @(posedge clk_sys);
        ci <= '0;
        rd(`NPI_OFF_CC, 8'h0a);
        per_flag <= 14'h0200;
        per_en <= 14'h0200;
        wait_vec(`NPI_VEC0 - 16'd18, `NPI_LVL2);
        results;
    end
endmodule
